// ==== servo_pi_p_mode_switch.sv ====
// speed-loop control-law selector: pi or p, plus speed bias
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module servo_pi_p_mode_switch
  import pmode_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire pmode_pkg::addr_t addr,
  input wire pmode_pkg::word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output pmode_pkg::word_t rdata,
  input wire logic proportional_select_n,
  input wire logic sample_en,
  input wire pmode_pkg::word_t torque_ref,
  input wire pmode_pkg::word_t speed_ref,
  input wire pmode_pkg::word_t accel,
  input wire pmode_pkg::word_t pos_error,
  output logic p_control,
  output logic mode_hit,
  output logic bias_on,
  output pmode_pkg::word_t speed_ref_out
);
  import pmode_pkg::*;
  `include "pmode_cfg.svh"

  pmode_if cfg ();       // settings bundle
  logic sel_n_s;         // synchronised select pin
  logic ext_p;           // pin asks for p control

  // settings registers
  pmode_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .cfg(cfg.regs)
  );

  // the pin comes from outside, so it is resynchronised first
  pmode_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(proportional_select_n),
    .q(sel_n_s)
  );

  // magnitudes of the detection quantities
  word_t trq_mag, spd_mag, acc_mag, err_mag;
  logic is_pos, is_spd;    // control method decode
  logic hit;               // mode switch condition
  logic bias_cond;         // bias condition
  logic p_req;             // combined p request
  word_t bias_sum;         // speed ref with bias applied

  always_comb begin
    trq_mag = mag16(torque_ref);
    spd_mag = mag16(speed_ref);
    acc_mag = mag16(accel);
    err_mag = mag16(pos_error);
  end

  // method decode and pin meaning
  always_comb begin
    is_spd = (cfg.method == 2'(METHOD_SPEED));
    is_pos = (cfg.method == 2'(METHOD_POSITION));
    // pin only counts in speed or position control
    ext_p = (is_spd || is_pos) && !sel_n_s;
  end

  // automatic detection point; strict "exceeds" compare throughout
  always_comb begin
    hit = 1'b0;
    case (msw_e'(cfg.modesel))
      MSW_TORQUE: hit = (trq_mag > cfg.trq_th);
      MSW_SPEED: hit = (spd_mag > cfg.spd_th);
      MSW_ACCEL: hit = (acc_mag > cfg.acc_th);
      // error compare ignored outside position control
      MSW_ERROR: hit = is_pos && (err_mag > cfg.err_th);
      MSW_OFF: hit = 1'b0;
      default: hit = 1'b0;
    endcase
  end

  // bias: position control and error beyond the addition width
  always_comb begin
    bias_cond = is_pos && (err_mag > cfg.biasw);
    bias_sum = speed_ref;
    if (bias_cond) begin
      // bias adds in the direction of the error; no wrap check
      // needed, references are far below full scale in practice
      if (pos_error[15]) begin
        bias_sum = word_t'(speed_ref - cfg.bias);
      end else begin
        bias_sum = word_t'(speed_ref + cfg.bias);
      end
    end
    p_req = ext_p || hit;
  end

  // output registers; flags and speed ref sampled on the loop enable pulse, read data every cycle
  logic p_q, p_d, hit_q, hit_d, bias_q, bias_d;
  word_t sro_q, sro_d;
  word_t rdata_q, rdata_d;

  always_comb begin
    p_d = p_q;
    hit_d = hit_q;
    bias_d = bias_q;
    sro_d = sro_q;
    if (sample_en) begin
      p_d = p_req;
      hit_d = hit;
      bias_d = bias_cond;
      sro_d = bias_sum;
    end
  end

  // read decode; unmapped indexes read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (rd && addr == `OFS_METHOD) begin
      rdata_d = {14'h0000, cfg.method};
    end else if (rd && addr == `OFS_MODESEL) begin
      rdata_d = {13'h0000, cfg.modesel};
    end else if (rd && addr == `OFS_BIAS) begin
      rdata_d = cfg.bias;
    end else if (rd && addr == `OFS_BIASW) begin
      rdata_d = cfg.biasw;
    end else if (rd && addr == `OFS_TRQ_TH) begin
      rdata_d = cfg.trq_th;
    end else if (rd && addr == `OFS_SPD_TH) begin
      rdata_d = cfg.spd_th;
    end else if (rd && addr == `OFS_ACC_TH) begin
      rdata_d = cfg.acc_th;
    end else if (rd && addr == `OFS_ERR_TH) begin
      rdata_d = cfg.err_th;
    end else if (rd && addr == `OFS_STATUS) begin
      rdata_d[`ST_PCTRL] = p_q;
      rdata_d[`ST_MODE_HIT] = hit_q;
      rdata_d[`ST_BIAS_ON] = bias_q;
      rdata_d[`ST_EXT_P] = ext_p;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      p_q <= 1'b0;
      hit_q <= 1'b0;
      bias_q <= 1'b0;
      sro_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      p_q <= p_d;
      hit_q <= hit_d;
      bias_q <= bias_d;
      sro_q <= sro_d;
      rdata_q <= rdata_d;
    end
  end

  assign p_control = p_q;
  assign mode_hit = hit_q;
  assign bias_on = bias_q;
  assign speed_ref_out = sro_q;
  assign rdata = rdata_q;
endmodule

// ==== pmode_cfg.svh ====
// register offsets, reset values, setting limits and field layout of the speed-loop selector
`ifndef PMODE_CFG_SVH
`define PMODE_CFG_SVH

// register offsets on the plain register port
`define OFS_METHOD    4'h0
`define OFS_MODESEL   4'h1
`define OFS_BIAS      4'h2
`define OFS_BIASW     4'h3
`define OFS_TRQ_TH    4'h4
`define OFS_SPD_TH    4'h5
`define OFS_ACC_TH    4'h6
`define OFS_ERR_TH    4'h7
`define OFS_STATUS    4'h8

// reset values
`define RST_METHOD    2'h0
`define RST_MODESEL   3'h0
`define RST_BIAS      16'h0000
`define RST_BIASW     16'h0007
`define RST_TRQ_TH    16'h00C8
`define RST_SPD_TH    16'h0000
`define RST_ACC_TH    16'h0000
`define RST_ERR_TH    16'h0000

// setting limits
`define MAX_BIAS      16'h01C2
`define MAX_BIASW     16'h00FA

// status fields
`define ST_PCTRL      0
`define ST_MODE_HIT   1
`define ST_BIAS_ON    2
`define ST_EXT_P      3

`endif

// ==== pmode_pkg.sv ====
// types shared by the speed-loop selector modules
package pmode_pkg;
  typedef logic [15:0] word_t;   // signed magnitudes carried as 16 bits
  typedef logic [3:0] addr_t;    // register index

  // control method codes
  typedef enum logic [1:0] {
    METHOD_SPEED,
    METHOD_POSITION,
    METHOD_TORQUE,
    METHOD_OTHER
  } method_e;

  // mode switch detection point
  typedef enum logic [2:0] {
    MSW_TORQUE,
    MSW_SPEED,
    MSW_ACCEL,
    MSW_ERROR,
    MSW_OFF
  } msw_e;

  // absolute value of a signed 16-bit quantity, saturated
  function automatic word_t mag16(input word_t v);
    word_t r;
    r = v;
    if (v[15]) begin
      r = (v == 16'h8000) ? 16'h7FFF : word_t'(~v + 16'h0001);
    end
    return r;
  endfunction
endpackage

// ==== pmode_if.sv ====
// settings carried from the register file to the mode logic
interface pmode_if;
  logic [1:0] method;     // control method selector
  logic [2:0] modesel;    // mode switch selector
  logic [15:0] bias;      // speed bias level
  logic [15:0] biasw;     // bias addition width
  logic [15:0] trq_th;    // torque threshold
  logic [15:0] spd_th;    // speed threshold
  logic [15:0] acc_th;    // acceleration threshold
  logic [15:0] err_th;    // error threshold
  modport regs (output method, modesel, bias, biasw, trq_th, spd_th,
                acc_th, err_th);
  modport core (input method, modesel, bias, biasw, trq_th, spd_th,
                acc_th, err_th);
endinterface

// ==== pmode_regs.sv ====
// register file holding the selector settings
module pmode_regs
  import pmode_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire pmode_pkg::addr_t addr,
  input wire pmode_pkg::word_t wdata,
  input wire logic wr,
  pmode_if.regs cfg
);
  `include "pmode_cfg.svh"

  logic [1:0] method_q, method_d;
  logic [2:0] modesel_q, modesel_d;
  word_t bias_q, bias_d, biasw_q, biasw_d;
  word_t trq_q, trq_d, spd_q, spd_d, acc_q, acc_d, err_q, err_d;

  // write decode; out-of-range settings are clipped to the limit
  always_comb begin
    method_d = method_q;
    modesel_d = modesel_q;
    bias_d = bias_q;
    biasw_d = biasw_q;
    trq_d = trq_q;
    spd_d = spd_q;
    acc_d = acc_q;
    err_d = err_q;
    if (wr && addr == `OFS_METHOD) begin
      method_d = wdata[1:0];
    end else if (wr && addr == `OFS_MODESEL) begin
      // codes above 4 act as "off" so no undefined detection point
      modesel_d = (wdata[2:0] > 3'h4) ? 3'h4 : wdata[2:0];
    end else if (wr && addr == `OFS_BIAS) begin
      bias_d = (wdata > `MAX_BIAS) ? `MAX_BIAS : wdata;
    end else if (wr && addr == `OFS_BIASW) begin
      biasw_d = (wdata > `MAX_BIASW) ? `MAX_BIASW : wdata;
    end else if (wr && addr == `OFS_TRQ_TH) begin
      trq_d = wdata;
    end else if (wr && addr == `OFS_SPD_TH) begin
      spd_d = wdata;
    end else if (wr && addr == `OFS_ACC_TH) begin
      acc_d = wdata;
    end else if (wr && addr == `OFS_ERR_TH) begin
      err_d = wdata;
    end
  end

  // registers, with documented defaults after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      method_q <= `RST_METHOD;
      modesel_q <= `RST_MODESEL;
      bias_q <= `RST_BIAS;
      biasw_q <= `RST_BIASW;
      trq_q <= `RST_TRQ_TH;
      spd_q <= `RST_SPD_TH;
      acc_q <= `RST_ACC_TH;
      err_q <= `RST_ERR_TH;
    end else begin
      method_q <= method_d;
      modesel_q <= modesel_d;
      bias_q <= bias_d;
      biasw_q <= biasw_d;
      trq_q <= trq_d;
      spd_q <= spd_d;
      acc_q <= acc_d;
      err_q <= err_d;
    end
  end

  assign cfg.method = method_q;
  assign cfg.modesel = modesel_q;
  assign cfg.bias = bias_q;
  assign cfg.biasw = biasw_q;
  assign cfg.trq_th = trq_q;
  assign cfg.spd_th = spd_q;
  assign cfg.acc_th = acc_q;
  assign cfg.err_th = err_q;
endmodule

// ==== pmode_sync.sv ====
// two-flop synchroniser for the external select pin
module pmode_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic d,
  output logic q
);
  logic s1_q, s1_d, s2_q, s2_d;

  // first stage feeds only the second
  always_comb begin
    s1_d = d;
    s2_d = s1_q;
  end

  // pin idles high (open), so reset to the released level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q = s2_q;
endmodule

// ==== pmode_properties.sv ====
// port-level assertions for the speed-loop selector
`include "pmode_cfg.svh"
module pmode_properties
  import pmode_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire pmode_pkg::addr_t addr,
  input wire pmode_pkg::word_t wdata,
  input wire logic wr,
  input wire logic proportional_select_n,
  input wire logic sample_en,
  input wire pmode_pkg::word_t speed_ref,
  input wire logic p_control,
  input wire logic mode_hit,
  input wire logic bias_on,
  input wire pmode_pkg::word_t speed_ref_out
);
  logic [1:0] meth_q, meth_d; // shadow of control method
  logic [2:0] msel_q, msel_d; // shadow of selector, any whole write value above 4 clipped to 4
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // track writes so the checks know the active settings
  always_comb begin
    meth_d = meth_q;
    msel_d = msel_q;
    if (wr && addr == `OFS_METHOD) meth_d = wdata[1:0];
    if (wr && addr == `OFS_MODESEL)
      msel_d = (wdata > 16'h0004) ? 3'h4 : wdata[2:0];
  end
  // plain register stage
  always_ff @(posedge clk) begin
    meth_q <= rstn ? meth_d : `RST_METHOD;
    msel_q <= rstn ? msel_d : `RST_MODESEL;
  end
  a_hit_forces_p: assert property (mode_hit |-> p_control)
    else $error("mode hit without p control");
  a_sel_off: assert property (sample_en && msel_q == 3'h4 |=> !mode_hit)
    else $error("hit while switching is off");
  a_err_pos_only: assert property (sample_en && msel_q == 3'h3
    && meth_q != 2'h1 |=> !mode_hit) else $error("error hit outside position");
  a_bias_pos_only: assert property (sample_en && meth_q != 2'h1
    |=> !bias_on) else $error("bias outside position control");
  a_plain_ref: assert property (sample_en ##1 !bias_on
    |-> speed_ref_out == $past(speed_ref)) else $error("ref changed, no bias");
  a_pin_low_p: assert property (sample_en && meth_q < 2'h2 && $past(rstn, 3)
    && !$past(proportional_select_n, 1) && !$past(proportional_select_n, 2)
    |=> p_control) else $error("pin low but pi");
  a_pin_ignored: assert property (sample_en && meth_q >= 2'h2
    && msel_q == 3'h4 |=> !p_control) else $error("pin honoured");
  a_pin_open_pi: assert property (sample_en && msel_q == 3'h4 && $past(rstn, 3)
    && $past(proportional_select_n, 1) && $past(proportional_select_n, 2)
    |=> !p_control) else $error("p with pin open");
endmodule
bind servo_pi_p_mode_switch pmode_properties pmode_properties_i (.clk(clk),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
  .proportional_select_n(proportional_select_n), .sample_en(sample_en),
  .speed_ref(speed_ref), .p_control(p_control), .mode_hit(mode_hit),
  .bias_on(bias_on), .speed_ref_out(speed_ref_out));

// ==== host_model.sv ====
// host controller model: select pin, references and loop-rate pulse
module host_model
  import pmode_pkg::*;
(
  input wire logic clk,
  output logic proportional_select_n,
  output logic sample_en,
  output pmode_pkg::word_t torque_ref,
  output pmode_pkg::word_t speed_ref,
  output pmode_pkg::word_t accel,
  output pmode_pkg::word_t pos_error
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div_q = 2'h0; // loop-rate divider
  initial begin
    proportional_select_n = 1'b1; // pin left open, pulled up
    sample_en = 1'b0;
    {torque_ref, speed_ref, accel, pos_error} = '0;
  end
  // one sample pulse every four cycles
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    sample_en <= (div_q == 2'h3);
  end
  // new references, changed just after an edge
  task automatic set_refs(input word_t t, s, a, e);
    @(posedge clk);
    {torque_ref, speed_ref, accel, pos_error} <= {t, s, a, e};
  endtask
  // host asks for p control, e.g. to stop creep
  task automatic ask_p(input logic on);
    @(posedge clk);
    proportional_select_n <= !on;
  endtask
endmodule

// ==== servo_pi_p_mode_switch_tb_top.sv ====
// self-checking testbench for the speed-loop selector
module servo_pi_p_mode_switch_tb_top;
  import pmode_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  addr_t addr = 4'h0;
  word_t wdata = 16'h0000;
  logic pin_n, smp, pc, hit, bon;
  word_t rdata, trq, spd, acc, perr, sro;
  int bad_count = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  host_model host_i (.clk(clk), .proportional_select_n(pin_n),
    .sample_en(smp), .torque_ref(trq), .speed_ref(spd), .accel(acc),
    .pos_error(perr));
  servo_pi_p_mode_switch servo_pi_p_mode_switch_i (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .proportional_select_n(pin_n), .sample_en(smp), .torque_ref(trq),
    .speed_ref(spd), .accel(acc), .pos_error(perr), .p_control(pc),
    .mode_hit(hit), .bias_on(bon), .speed_ref_out(sro));
  task automatic chk(input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // p_control and mode_hit together
  task automatic flags(input logic [1:0] e);
    chk(word_t'({pc, hit}), word_t'(e));
  endtask
  task automatic wr_reg(input addr_t a, input word_t d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input addr_t a, input word_t e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // let two sample pulses pass so the synced pin is seen too
  task automatic settle();
    repeat (2) begin
      @(posedge clk);
      while (!smp) @(posedge clk);
    end
    #1;
  endtask
  task automatic s_defaults();
    word_t rv[8];
    rv = '{16'h0000, 16'h0000, 16'h0000, 16'h0007,
           16'h00C8, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) rd_chk(addr_t'(i), rv[i]);
    rd_chk(4'hF, 16'h0000);
    host_i.set_refs(16'h00C8, 16'h0000, 16'h0000, 16'h0000);
    settle();
    flags(2'b00);
    host_i.set_refs(16'hFF37, 16'h0000, 16'h0000, 16'h0000);
    settle();
    flags(2'b11);
  endtask
  // each selector watches only its own input; others held far over
  task automatic s_modes();
    word_t r[4];
    for (int a = 4; a < 8; a++) wr_reg(addr_t'(a), 16'h0064);
    wr_reg(4'h0, 16'h0001);
    for (int m = 0; m < 5; m++) begin
      wr_reg(4'h1, word_t'(m));
      for (int k = 0; k < 2; k++) begin
        foreach (r[j]) r[j] = (j == m) ? 16'h0064 + word_t'(k) : 16'h7FFF;
        host_i.set_refs(r[0], r[1], r[2], r[3]);
        settle();
        flags((m < 4 && k == 1) ? 2'b11 : 2'b00);
      end
    end
    wr_reg(4'h1, 16'h0007);
    rd_chk(4'h1, 16'h0004);
  endtask
  task automatic s_pin();
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h1, 16'h0003);
    settle();
    flags(2'b00);
    wr_reg(4'h1, 16'h0004);
    host_i.ask_p(1'b1);
    settle();
    flags(2'b10);
    wr_reg(4'h0, 16'h0002);
    settle();
    flags(2'b00);
    wr_reg(4'h0, 16'h0001);
    host_i.ask_p(1'b0);
    settle();
    flags(2'b00);
  endtask
  task automatic sr(input word_t e, input word_t x, input logic b);
    host_i.set_refs(16'h0000, 16'h0064, 16'h0000, e);
    settle();
    chk(sro, x);
    chk(word_t'(bon), word_t'(b));
  endtask
  task automatic s_bias();
    wr_reg(4'h2, 16'h01F4);
    rd_chk(4'h2, 16'h01C2);
    wr_reg(4'h3, 16'h012C);
    rd_chk(4'h3, 16'h00FA);
    wr_reg(4'h3, 16'h0007);
    sr(16'h0007, 16'h0064, 1'b0);
    sr(16'h0008, 16'h0226, 1'b1);
    rd_chk(4'h8, 16'h0004);
    sr(16'hFFF8, 16'hFEA2, 1'b1);
    wr_reg(4'h0, 16'h0000);
    sr(16'hFFF8, 16'h0064, 1'b0);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    s_defaults();
    s_modes();
    s_pin();
    s_bias();
    end_sim();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #500000;
    bad_count++;
    end_sim();
  end
endmodule
